// ### rtl/wscp_pkg.sv
// Constants and types of the weigh serial command port.
package wscp_pkg;
  localparam int BAUD_TAB [0:5] = '{300, 600, 1200, 2400, 4800, 9600};
  localparam logic [2:0] BAUD_LAST = 3'h5;
  localparam logic [2:0] BAUD_RST = 3'h5;
  localparam logic [1:0] FMT_7E = 2'h0;
  localparam logic [1:0] FMT_7O = 2'h1;
  localparam logic [1:0] FMT_7N = 2'h2;
  localparam logic [1:0] FMT_8N = 2'h3;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_SETTLE = 2'h1;
  localparam logic [1:0] AUTO_TIMED = 2'h2;
  localparam logic [1:0] AUTO_AUTO_CONTINUOUS = 2'h3;
  localparam logic [11:0] INTV_MIN = 12'h001;
  localparam logic [11:0] INTV_MAX = 12'hE10;
  localparam logic [11:0] INTV_RST = 12'h001;
  localparam logic [2:0] UNIT_G = 3'h1;
  localparam logic [2:0] UNIT_LBOZ = 3'h5;
  localparam logic [2:0] SEL_BAUD = 3'h0;
  localparam logic [2:0] SEL_FMT = 3'h1;
  localparam logic [2:0] SEL_STOP = 3'h2;
  localparam logic [2:0] SEL_FLOW = 3'h3;
  localparam logic [2:0] SEL_STAB = 3'h4;
  localparam logic [2:0] SEL_AUTO = 3'h5;
  localparam logic [2:0] SEL_INTV_UP = 3'h6;
  localparam logic [2:0] SEL_INTV_DN = 3'h7;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [19:0] NUM_CAP = 20'h1869F;
  localparam logic [39:0] UNIT_TXT [1:5] =
    '{"g    ", "kg   ", "lb   ", "oz   ", "lb:oz"};
  localparam logic [23:0] LEG_TXT [0:3] = '{"G  ", "NET", "T  ", "   "};
  localparam logic [55:0] LOCK_TXT = " LOCKED";
  localparam logic [4:0] RPT_LEN = 5'h15;
  localparam logic [4:0] UNIT_LEN = 5'h07;
  localparam logic [4:0] VER_LEN = 5'h0A;
  localparam logic [4:0] VER_LFT_LEN = 5'h11;
  localparam logic [3:0] TX_BITS_1 = 4'h9;
  localparam logic [3:0] TX_BITS_2 = 4'hA;
  typedef enum logic [2:0] {
    MSG_W = 3'b001,
    MSG_U = 3'b010,
    MSG_V = 3'b100
  } wscp_msg_t;
endpackage

// ### rtl/wscp_fifo.sv
// Byte FIFO between the report formatter and the transmitter.
`timescale 1ns/1ps
module wscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  // Pointers wrap naturally, so DEPTH must be a power of two.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic wr;
  logic rd;
  assign o_in_ready = cnt != FULL;
  assign o_out_valid = cnt != '0;
  assign o_out_data = mem[rp];
  assign wr = i_in_valid && o_in_ready;
  assign rd = o_out_valid && i_out_ready;
  always_ff @(posedge i_ref_clk) begin
    if (wr) begin
      mem[wp] <= i_in_data;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= wp + AW'(wr);
      rp <= rp + AW'(rd);
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

// ### rtl/wscp_port.sv
// Serial command interpreter and report formatter of the weigh indicator.
`timescale 1ns/1ps
module wscp_port
  import wscp_pkg::*;
#(
  parameter int CLK_HZ = 20_000_000,
  parameter int FIFO_DEPTH = 16,
  // Name and revision text; the value is arbitrary.
  parameter logic [63:0] NAME_REV = "WSCP 1.0"
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rxd,
  input wire logic [23:0] i_weight_bcd,
  input wire logic [2:0] i_dp_pos,
  input wire logic i_weight_neg,
  input wire logic i_stable,
  input wire logic [1:0] i_legend,
  input wire logic i_trade_lock,
  input wire logic i_print_key,
  input wire logic i_menu_adv,
  input wire logic [2:0] i_menu_sel,
  output logic o_txd,
  output logic o_zero,
  output logic o_tare,
  output logic o_tare_load,
  output logic o_tare_clear,
  output logic [19:0] o_tare_val,
  output logic [2:0] o_unit,
  output logic [2:0] o_baud_sel,
  output logic [1:0] o_fmt,
  output logic o_two_stop,
  output logic o_flow_on,
  output logic o_stable_only,
  output logic [1:0] o_auto,
  output logic [11:0] o_interval,
  output logic o_tx_paused
);
  localparam int PRE_W = $clog2(CLK_HZ);
  typedef enum logic [3:0] {
    R_IDLE = 4'b0001,
    R_START = 4'b0010,
    R_DATA = 4'b0100,
    R_STOP = 4'b1000
  } wscp_rx_t;
  typedef enum logic [1:0] {
    F_IDLE = 2'b01,
    F_SEND = 2'b10
  } wscp_fst_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_SHIFT = 2'b10
  } wscp_tx_t;

  logic [16:0] div_tab [0:5];
  logic [16:0] div;
  for (genvar g = 0; g < 6; g++) begin : g_div
    assign div_tab[g] = 17'(CLK_HZ / BAUD_TAB[g]);
  end
  assign div = div_tab[o_baud_sel];

  // Receiver: samples each bit at its middle.
  wscp_rx_t rx_st;
  logic [16:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_vld;
  logic [7:0] rx_byte;
  logic [3:0] rx_n;
  logic rx_par_ok;
  always_comb begin
    rx_n = (o_fmt == FMT_7N) ? 4'h7 : 4'h8;
    rx_byte = (o_fmt == FMT_8N) ? rx_sh : {1'b0, rx_sh[6:0]};
    rx_par_ok = 1'b1;
    if (o_fmt == FMT_7E) begin
      rx_par_ok = ~^rx_sh;
    end else if (o_fmt == FMT_7O) begin
      rx_par_ok = ^rx_sh;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_st <= R_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_vld <= 1'b0;
    end else begin
      rx_vld <= 1'b0;
      rx_cnt <= rx_cnt - 17'h1;
      unique case (rx_st)
        R_IDLE: begin
          if (!i_rxd) begin
            rx_st <= R_START;
            rx_cnt <= {1'b0, div[16:1]};
          end
        end
        R_START: begin
          if (rx_cnt == '0) begin
            rx_cnt <= div - 17'h1;
            rx_bit <= '0;
            rx_sh <= '0;
            rx_st <= i_rxd ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_cnt == '0) begin
            rx_cnt <= div - 17'h1;
            rx_sh[rx_bit[2:0]] <= i_rxd;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == rx_n - 4'h1) begin
              rx_st <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (rx_cnt == '0) begin
            rx_st <= R_IDLE;
            rx_vld <= i_rxd && rx_par_ok;
          end
        end
      endcase
    end
  end

  // Command parser: optional decimal prefix, then one or two letters.
  logic [7:0] ch;
  logic is_flow;
  logic is_dig;
  logic [19:0] num;
  logic has_num;
  logic bad;
  logic esc;
  logic [1:0] nlet;
  logic [7:0] l1;
  logic [7:0] l2;
  logic c_fr, c_cr, w1, w2, c_now, c_prt, c_auto_continuous, c_settle, c_intv;
  logic c_zero, c_tare, c_tload, c_pu, c_su, c_pv;
  always_comb begin
    ch = rx_byte;
    if (rx_byte >= "a" && rx_byte <= "z") begin
      ch = rx_byte - 8'h20;
    end
    is_flow = o_flow_on && (ch == CH_XON || ch == CH_XOFF);
    is_dig = ch >= "0" && ch <= "9";
    c_fr = rx_vld && esc && ch == "R";
    c_cr = rx_vld && ch == CH_CR && !bad && !esc;
    w1 = nlet == 2'h1;
    w2 = nlet == 2'h2;
    c_now = c_cr && w2 && !has_num && l1 == "I" && l2 == "P";
    c_prt = c_cr && w1 && !has_num && l2 == "P";
    c_auto_continuous = c_cr && w2 && !has_num && l1 == "C" && l2 == "P";
    c_settle = c_cr && w2 && !has_num && l1 == "S" && l2 == "P";
    c_intv = c_cr && w1 && has_num && l2 == "P" && num >= 20'(INTV_MIN)
      && num <= 20'(INTV_MAX);
    c_zero = c_cr && w1 && !has_num && l2 == "Z";
    c_tare = c_cr && w1 && !has_num && l2 == "T";
    c_tload = c_cr && w1 && has_num && l2 == "T";
    c_pu = c_cr && w2 && !has_num && l1 == "P" && l2 == "U";
    c_su = c_cr && w1 && has_num && l2 == "U" && num >= 20'(UNIT_G)
      && num <= 20'(UNIT_LBOZ);
    c_pv = c_cr && w2 && !has_num && l1 == "P" && l2 == "V";
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      num <= '0;
      has_num <= 1'b0;
      bad <= 1'b0;
      esc <= 1'b0;
      nlet <= '0;
      l1 <= '0;
      l2 <= '0;
    end else if (rx_vld && !is_flow) begin
      esc <= ch == CH_ESC;
      if (ch == CH_CR || ch == CH_ESC || c_fr) begin
        // Any line, known or not, is flushed here.
        num <= '0;
        has_num <= 1'b0;
        bad <= 1'b0;
        nlet <= '0;
      end else if (ch == CH_LF || ch == CH_SP) begin
        // A trailing LF after CR is harmless.
        bad <= bad;
      end else if (is_dig && nlet == 2'h0) begin
        has_num <= 1'b1;
        if (num > NUM_CAP) begin
          bad <= 1'b1;
        end else begin
          num <= 20'(num * 20'd10 + {12'h0, ch - 8'h30});
        end
      end else if (ch >= "A" && ch <= "Z") begin
        l1 <= l2;
        l2 <= ch;
        nlet <= (nlet == 2'h3) ? nlet : nlet + 2'h1;
      end else begin
        bad <= 1'b1;
      end
    end
  end

  // Menu and serial settings.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_baud_sel <= BAUD_RST;
      o_fmt <= FMT_8N;
      o_two_stop <= 1'b0;
      o_flow_on <= 1'b1;
      o_stable_only <= 1'b0;
      o_auto <= AUTO_OFF;
      o_interval <= INTV_RST;
    end else if (c_fr) begin
      o_baud_sel <= BAUD_RST;
      o_fmt <= FMT_8N;
      o_two_stop <= 1'b0;
      o_flow_on <= 1'b1;
      o_stable_only <= 1'b0;
      o_auto <= AUTO_OFF;
      o_interval <= INTV_RST;
    end else begin
      if (i_menu_adv) begin
        unique case (i_menu_sel)
          SEL_BAUD: begin
            o_baud_sel <= (o_baud_sel == BAUD_LAST) ? 3'h0
              : o_baud_sel + 3'h1;
          end
          SEL_FMT: o_fmt <= o_fmt + 2'h1;
          SEL_STOP: o_two_stop <= !o_two_stop;
          SEL_FLOW: o_flow_on <= !o_flow_on;
          SEL_STAB: o_stable_only <= !o_stable_only;
          SEL_AUTO: o_auto <= o_auto + 2'h1;
          SEL_INTV_UP: begin
            o_interval <= (o_interval == INTV_MAX) ? INTV_MIN
              : o_interval + 12'h1;
          end
          SEL_INTV_DN: begin
            o_interval <= (o_interval == INTV_MIN) ? INTV_MAX
              : o_interval - 12'h1;
          end
        endcase
      end
      if (c_auto_continuous) begin
        o_auto <= AUTO_AUTO_CONTINUOUS;
      end
      if (c_settle) begin
        o_auto <= AUTO_SETTLE;
      end
      if (c_intv) begin
        o_auto <= AUTO_TIMED;
        o_interval <= num[11:0];
      end
    end
  end

  // Unit select is blocked while the trade lock holds.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_unit <= UNIT_G;
    end else if (!i_trade_lock) begin
      if (c_fr) begin
        o_unit <= UNIT_G;
      end else if (c_su) begin
        o_unit <= num[2:0];
      end
    end
  end

  // Button-equivalent pulses and tare download.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_zero <= 1'b0;
      o_tare <= 1'b0;
      o_tare_load <= 1'b0;
      o_tare_clear <= 1'b0;
      o_tare_val <= '0;
    end else begin
      o_zero <= c_zero;
      o_tare <= c_tare;
      o_tare_load <= c_tload && num != '0;
      o_tare_clear <= c_tload && num == '0 && !i_trade_lock;
      if (c_tload && num != '0) begin
        o_tare_val <= num;
      end
    end
  end

  // Report requests; a set in the same cycle as the clear wins.
  wscp_fst_t f_st;
  logic f_go;
  wscp_msg_t f_go_msg;
  logic w_req, now_req, u_req, v_req, stab_d;
  logic [PRE_W-1:0] pre;
  logic [11:0] secs;
  logic tick;
  assign tick = pre == PRE_W'(CLK_HZ - 1);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      w_req <= 1'b0;
      now_req <= 1'b0;
      u_req <= 1'b0;
      v_req <= 1'b0;
      stab_d <= 1'b0;
      pre <= '0;
      secs <= '0;
    end else begin
      stab_d <= i_stable;
      pre <= tick ? '0 : pre + PRE_W'(1);
      if (f_go && f_go_msg == MSG_W) begin
        w_req <= 1'b0;
        now_req <= 1'b0;
      end
      if (f_go && f_go_msg == MSG_U) begin
        u_req <= 1'b0;
      end
      if (f_go && f_go_msg == MSG_V) begin
        v_req <= 1'b0;
      end
      if (o_auto != AUTO_TIMED) begin
        secs <= '0;
      end else if (tick) begin
        secs <= secs + 12'h1;
        if (secs + 12'h1 >= o_interval) begin
          secs <= '0;
          w_req <= 1'b1;
        end
      end
      if (c_prt || (i_print_key && o_auto == AUTO_OFF)) begin
        w_req <= 1'b1;
      end
      if (o_auto == AUTO_SETTLE && i_stable && !stab_d) begin
        w_req <= 1'b1;
      end
      if (o_auto == AUTO_AUTO_CONTINUOUS) begin
        w_req <= 1'b1;
      end
      if (c_now) begin
        now_req <= 1'b1;
      end
      if (c_pu) begin
        u_req <= 1'b1;
      end
      if (c_pv) begin
        v_req <= 1'b1;
      end
    end
  end

  // Report formatter feeding the FIFO.
  wscp_msg_t msg;
  logic [4:0] idx;
  logic [4:0] len;
  logic [23:0] cap_bcd;
  logic [2:0] cap_dp;
  logic [2:0] cap_unit;
  logic [1:0] cap_leg;
  logic cap_neg, cap_stab, cap_lock;
  logic [5:0] nz;
  logic [7:0] f_byte;
  logic f_rdy;
  logic f_push;
  for (genvar g = 0; g < 6; g++) begin : g_nz
    assign nz[g] = |cap_bcd[23:4*g];
  end
  always_comb begin
    f_go = 1'b0;
    f_go_msg = MSG_W;
    if (f_st == F_IDLE) begin
      if (now_req) begin
        f_go = 1'b1;
      end else if (u_req) begin
        f_go = 1'b1;
        f_go_msg = MSG_U;
      end else if (v_req) begin
        f_go = 1'b1;
        f_go_msg = MSG_V;
      end else if (w_req && (!o_stable_only || i_stable)) begin
        f_go = 1'b1;
      end
    end
  end

  function automatic logic [7:0] wchar(input logic [2:0] p);
    logic [2:0] k;
    logic [2:0] j;
    k = 3'h6 - p;
    j = (cap_dp != 3'h0 && k > cap_dp) ? k - 3'h1 : k;
    if (cap_dp != 3'h0 && k == cap_dp) begin
      return ".";
    end
    if (j > 3'h5 || (!nz[j] && j > cap_dp)) begin
      return CH_SP;
    end
    return {4'h3, cap_bcd[4*j+:4]};
  endfunction

  always_comb begin
    f_byte = CH_SP;
    if (idx == len - 5'h2) begin
      f_byte = CH_CR;
    end else if (idx == len - 5'h1) begin
      f_byte = CH_LF;
    end else begin
      unique case (msg)
        MSG_W: begin
          if (idx == 5'h0) begin
            f_byte = cap_neg ? "-" : CH_SP;
          end else if (idx >= 5'h2 && idx <= 5'h8) begin
            f_byte = wchar(3'(idx - 5'h2));
          end else if (idx >= 5'hA && idx <= 5'hE) begin
            f_byte = UNIT_TXT[cap_unit][8*(14-idx)+:8];
          end else if (idx == 5'hF) begin
            f_byte = cap_stab ? CH_SP : "?";
          end else if (idx >= 5'h10) begin
            f_byte = LEG_TXT[cap_leg][8*(18-idx)+:8];
          end
        end
        MSG_U: f_byte = UNIT_TXT[cap_unit][8*(4-idx)+:8];
        MSG_V: begin
          if (idx < 5'h8) begin
            f_byte = NAME_REV[8*(7-idx)+:8];
          end else begin
            f_byte = LOCK_TXT[8*(14-idx)+:8];
          end
        end
      endcase
    end
  end

  assign f_push = f_st == F_SEND && f_rdy;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      f_st <= F_IDLE;
      msg <= MSG_W;
      idx <= '0;
      len <= RPT_LEN;
      cap_bcd <= '0;
      cap_dp <= '0;
      cap_unit <= UNIT_G;
      cap_leg <= '0;
      cap_neg <= 1'b0;
      cap_stab <= 1'b0;
      cap_lock <= 1'b0;
    end else begin
      unique case (f_st)
        F_IDLE: begin
          if (f_go) begin
            f_st <= F_SEND;
            msg <= f_go_msg;
            idx <= '0;
            cap_bcd <= i_weight_bcd;
            cap_dp <= i_dp_pos;
            cap_unit <= o_unit;
            cap_leg <= i_legend;
            cap_neg <= i_weight_neg;
            cap_stab <= i_stable;
            cap_lock <= i_trade_lock;
            unique case (f_go_msg)
              MSG_W: len <= RPT_LEN;
              MSG_U: len <= UNIT_LEN;
              MSG_V: len <= i_trade_lock ? VER_LFT_LEN : VER_LEN;
            endcase
          end
        end
        F_SEND: begin
          if (f_rdy) begin
            idx <= idx + 5'h1;
            if (idx == len - 5'h1) begin
              f_st <= F_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Transmitter with XON/XOFF pause between characters.
  wscp_tx_t tx_st;
  logic [16:0] tx_cnt;
  logic [9:0] tx_sh;
  logic [3:0] tx_left;
  logic q_vld;
  logic [7:0] q_dat;
  logic q_pop;
  logic slot8;
  assign q_pop = tx_st == T_IDLE && q_vld && !(o_flow_on && o_tx_paused);
  always_comb begin
    unique case (o_fmt)
      FMT_8N: slot8 = q_dat[7];
      FMT_7E: slot8 = ^q_dat[6:0];
      FMT_7O: slot8 = ~^q_dat[6:0];
      FMT_7N: slot8 = 1'b1;
    endcase
  end
  wscp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(f_st == F_SEND),
    .i_in_data(f_byte),
    .o_in_ready(f_rdy),
    .o_out_valid(q_vld),
    .o_out_data(q_dat),
    .i_out_ready(q_pop)
  );
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_paused <= 1'b0;
    end else if (c_fr || !o_flow_on) begin
      o_tx_paused <= 1'b0;
    end else if (rx_vld && rx_byte == CH_XOFF) begin
      o_tx_paused <= 1'b1;
    end else if (rx_vld && rx_byte == CH_XON) begin
      o_tx_paused <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st <= T_IDLE;
      tx_cnt <= '0;
      tx_sh <= '1;
      tx_left <= '0;
      o_txd <= 1'b1;
    end else begin
      unique case (tx_st)
        T_IDLE: begin
          if (q_pop) begin
            tx_st <= T_SHIFT;
            o_txd <= 1'b0;
            tx_sh <= {2'b11, slot8, q_dat[6:0]};
            tx_left <= o_two_stop ? TX_BITS_2 : TX_BITS_1;
            tx_cnt <= div - 17'h1;
          end
        end
        T_SHIFT: begin
          tx_cnt <= tx_cnt - 17'h1;
          if (tx_cnt == '0) begin
            tx_cnt <= div - 17'h1;
            if (tx_left == '0) begin
              tx_st <= T_IDLE;
            end else begin
              o_txd <= tx_sh[0];
              tx_sh <= {1'b1, tx_sh[9:1]};
              tx_left <= tx_left - 4'h1;
            end
          end
        end
      endcase
    end
  end

  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_cr_push;
    f_push && f_byte == CH_CR;
  endsequence
  sequence s_lf_next;
    f_st == F_SEND && f_byte == CH_LF;
  endsequence
  chk_factory_dflt:
  assert property (c_fr |=> o_baud_sel == BAUD_RST && o_fmt == FMT_8N
    && o_flow_on && !o_stable_only && o_auto == AUTO_OFF)
    else $error("factory defaults not restored");
  chk_baud_step:
  assert property (i_menu_adv && i_menu_sel == SEL_BAUD && !c_fr |=>
    o_baud_sel == (($past(o_baud_sel) == BAUD_LAST) ? 3'h0
    : $past(o_baud_sel) + 3'h1))
    else $error("baud setting stepped wrongly");
  chk_fmt_step:
  assert property (i_menu_adv && i_menu_sel == SEL_FMT && !c_fr |=>
    o_fmt == $past(o_fmt) + 2'h1) else $error("format stepped wrongly");
  chk_xoff_hold:
  assert property (o_flow_on && o_tx_paused && tx_st == T_IDLE |=>
    tx_st == T_IDLE && o_txd) else $error("sent while paused");
  chk_stable_gate:
  assert property (f_go && f_go_msg == MSG_W && !now_req |->
    !o_stable_only || i_stable) else $error("unstable report sent");
  chk_intv_range:
  assert property (o_interval >= INTV_MIN && o_interval <= INTV_MAX)
    else $error("interval out of range");
  chk_now_first:
  assert property (now_req && f_st == F_IDLE |=> f_st == F_SEND
    && msg == MSG_W && idx == 5'h0) else $error("print-now delayed");
  chk_crlf_end:
  assert property (s_cr_push |=> s_lf_next) else $error("CR not followed by LF");
  chk_unit_lock:
  assert property (i_trade_lock |=> o_unit == $past(o_unit))
    else $error("unit changed under lock");
endmodule

// ### testbench/wscp_host.sv
// Host model: serial sender and receiver, 8N1 at DIV clocks per bit.
`timescale 1ns/1ps
module wscp_host #(
  parameter int DIV = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  initial o_rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_ref_clk);
      o_rxd = f[i];
      repeat (DIV - 1) @(negedge i_ref_clk);
    end
  endtask
  // Samples each bit at its middle, least significant bit first.
  always begin
    @(negedge i_txd);
    repeat (DIV + DIV / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      rx_b[i] = i_txd;
      repeat (DIV) @(posedge i_ref_clk);
    end
    rx_q.push_back(rx_b);
  end
endmodule

// ### testbench/wscp_port_bench.sv
// Bench: host commands, menu stepping and report checks for the port.
`timescale 1ns/1ps
module wscp_port_bench;
  import wscp_pkg::*;
  logic clk, rst, adv, txd, zero, rxd, lock, key, stab, sonly, paused;
  logic [19:0] tare_val;
  logic [11:0] intv;
  logic [55:0] ut;
  logic [2:0] sel, unit, baud;
  logic [1:0] fmt, auto;
  logic [167:0] rpt;
  int err_count, samples_checked, zero_n, cyc;
  wscp_port #(.CLK_HZ(96000)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_rxd(rxd),
    .i_weight_bcd(24'h001234), .i_dp_pos(3'h0), .i_weight_neg(1'b1),
    .i_stable(stab), .i_legend(2'h1), .i_trade_lock(lock),
    .i_print_key(key), .i_menu_adv(adv), .i_menu_sel(sel),
    .o_txd(txd), .o_zero(zero), .o_tare(), .o_tare_load(),
    .o_tare_clear(), .o_tare_val(tare_val), .o_unit(unit),
    .o_baud_sel(baud), .o_fmt(fmt), .o_two_stop(), .o_flow_on(),
    .o_stable_only(sonly), .o_auto(auto), .o_interval(intv),
    .o_tx_paused(paused)
  );
  wscp_host host_u (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic step(logic [2:0] s);
    @(negedge clk);
    sel = s;
    adv = 1'b1;
    @(negedge clk);
    adv = 1'b0;
    @(negedge clk);
  endtask
  task automatic cmd(string s);
    foreach (s[i]) host_u.send(s[i]);
    repeat (30) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    zero_n += (zero === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    rst = 1'b1;
    adv = 1'b0;
    sel = 3'h0;
    lock = 1'b0;
    key = 1'b0;
    stab = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk("baud", BAUD_RST, baud);
    chk("fmt", FMT_8N, fmt);
    chk("auto", AUTO_OFF, auto);
    for (int i = 0; i < 6; i++) begin
      step(SEL_BAUD);
      chk("baud", i, baud);
    end
    for (int i = 0; i < 4; i++) begin
      step(SEL_FMT);
      chk("fmt", i, fmt);
    end
    cmd("Z\r");
    chk("zero", 1, zero_n);
    cmd("ip\r\n");
    while (host_u.rx_q.size() < 21) @(negedge clk);
    rpt = {"-    1234 g    ?NET", CH_CR, CH_LF};
    for (int i = 0; i < 21; i++) begin
      chk("rpt", rpt[167-8*i -: 8], host_u.rx_q[i]);
    end
    step(SEL_STAB);
    chk("sonly", 1, sonly);
    cmd("P\r");
    repeat (200) @(negedge clk);
    chk("held", 21, host_u.rx_q.size());
    stab = 1'b1;
    while (host_u.rx_q.size() < 42) @(negedge clk);
    chk("stab", CH_SP, host_u.rx_q[36]);
    chk("lf", CH_LF, host_u.rx_q[41]);
    cmd("3U\r");
    chk("unit", 3, unit);
    cmd("9U\r");
    chk("unit", 3, unit);
    lock = 1'b1;
    cmd("2U\r");
    chk("unit", 3, unit);
    lock = 1'b0;
    cmd("pu\r");
    while (host_u.rx_q.size() < 49) @(negedge clk);
    ut = {"lb   ", CH_CR, CH_LF};
    for (int i = 0; i < 7; i++) begin
      chk("unit_rpt", ut[55-8*i -: 8], host_u.rx_q[42+i]);
    end
    cmd("25T\r");
    chk("tare", 25, tare_val);
    step(SEL_AUTO);
    chk("auto", AUTO_SETTLE, auto);
    cmd("5P\r");
    chk("auto", AUTO_TIMED, auto);
    chk("intv", 5, intv);
    cmd({CH_ESC, "R"});
    chk("unit", UNIT_G, unit);
    chk("auto", AUTO_OFF, auto);
    chk("sonly", 0, sonly);
    chk("intv", INTV_RST, intv);
    host_u.send(CH_XOFF);
    repeat (30) @(negedge clk);
    chk("pause", 1, paused);
    host_u.send(CH_XON);
    repeat (30) @(negedge clk);
    chk("pause", 0, paused);
    complete_run;
  end
endmodule
